// ===== rtl/wsws_top.sv
// watchdog, sleep mode, brownout and warm-up supervisor with apb registers
//
// Functional notes
// - watchdog counts own rc ticks, also deep sleep
// - watchdog overflow forces full device reset
// - option bit enables watchdog, default on
// - select bits pick timeout 4096ms down to 1ms
// - read-only bit 3 flags watchdog reset
// - any watchdog register access restarts count
// - light sleep halts cpu, peripherals keep running
// - deep sleep stops oscillator; watchdog, comparator run
// - light sleep wakes on any interrupt
// - deep sleep wakes on port, comparator, watchdog; here a watchdog overflow in deep sleep resets the device instead
// - wake runs service routine before next instruction
// - enabled comparator change wakes either sleep mode
// - power-on or pin reset waits 4096/16384 clocks
// - other resets wait 128 rc or 4096 clocks
// - brownout holds reset while supply is low
// - options enable brownout and choose its threshold
// - three option bits choose oscillator type
// - range option bit chooses oscillator range
// - reset pin option or port bit function
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module wsws_top
    import wsws_pkg::*;
#(
    parameter int WDT_CNT_W        = 13,
    parameter int WDT_TICKS_PER_MS = WSWS_WDT_TICKS_PER_MS,
    parameter int WARM_POR_LO      = WSWS_WARM_POR_LO,
    parameter int WARM_POR_HI      = WSWS_WARM_POR_HI,
    parameter int WARM_RC          = WSWS_WARM_RC,
    parameter int WARM_XTAL        = WSWS_WARM_XTAL
) (
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        WDT_RC_TICK,
    input  wire logic        LIGHT_SLEEP_REQ,
    input  wire logic        DEEP_SLEEP_REQ,
    input  wire logic        IRQ_ANY,
    input  wire logic        PORT_IRQ,
    input  wire logic        CMP_IRQ_EN,
    input  wire logic        COMPARATOR_RESULT_BIT,
    input  wire logic        SUPPLY_LOW_HI_TH,
    input  wire logic        SUPPLY_LOW_LO_TH,
    input  wire logic        RESET_PIN_N,
    output logic             SYS_RESET,
    output logic             CPU_RUN,
    output logic             OSC_RUN,
    output logic             PERIPH_RUN,
    output logic             WDT_RUN,
    output logic             CMP_RUN,
    output logic             ISR_FIRST,
    output logic             PORT_A_BIT3_GPIO
);
    localparam int WARM_W = 15;

    wsws_state_t        state;
    wsws_state_t        next_state;
    logic [7:0]         opt;
    logic               opt_locked;
    logic [2:0]         wdt_sel;
    logic               wdt_flag;
    logic               rst_long;
    logic               next_rst_long;
    logic               warm_rst;
    logic               next_warm_rst;
    logic               isr_pend;
    logic               cmp_prev;
    logic               wdt_ovf;
    logic [WDT_CNT_W-1:0] wdt_count;
    logic [WDT_CNT_W-1:0] wdt_load;
    logic               warm_start;
    logic               warm_busy;
    logic               warm_done;
    logic [WARM_W-1:0]  warm_len;
    logic               acc;
    logic               acc_wr;
    logic [7:0]         idx;
    logic               hit_wdt;
    logic               hit_opt;
    logic               hit_stat;
    logic               wdt_restart;
    logic               wdt_en;
    logic               wdt_go;
    logic               bor_low;
    logic               pin_rst;
    logic               cmp_wake;
    logic               osc_rc;
    logic               wake_evt;

    // apb decode; a transfer completes on psel, penable and pready
    assign idx      = {2'b00, PADDR[7:2]};
    assign hit_wdt  = idx == WSWS_IDX_WDT;
    assign hit_opt  = idx == WSWS_IDX_OPT;
    assign hit_stat = idx == WSWS_IDX_STAT;
    assign acc      = PSEL && PENABLE && PREADY;
    assign acc_wr   = acc && PWRITE;

    // one wait state, answer registered
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0;
        end else if (PSEL && PENABLE && !PREADY) begin
            PREADY  <= 1'b1;
            PSLVERR <= !(hit_wdt || hit_opt || hit_stat);
            PRDATA  <= 32'h0;
            if (!PWRITE && hit_wdt) begin
                PRDATA <= {28'h0, wdt_flag, wdt_sel};
            end else if (!PWRITE && hit_opt) begin
                PRDATA <= {23'h0, opt_locked, opt};
            end else if (!PWRITE && hit_stat) begin
                PRDATA <= {27'h0, state};
            end
        end else begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0;
        end
    end

    // factory options, settable once then locked until power-on
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            opt        <= WSWS_OPT_RST;
            opt_locked <= 1'b0;
        end else if (acc_wr && hit_opt && !opt_locked) begin
            opt        <= PWDATA[7:0];
            opt_locked <= 1'b1;
        end
    end

    assign wdt_en  = opt[WSWS_OPT_WDT_BIT];
    assign osc_rc  = opt[2:0] == WSWS_OSC_IRC || opt[2:0] == WSWS_OSC_ERC;
    assign pin_rst = !opt[WSWS_OPT_PIN_BIT] && !RESET_PIN_N;
    // low level option picks the lower threshold
    assign bor_low = opt[WSWS_OPT_BOR_BIT]
                     && (opt[WSWS_OPT_LVL_BIT] ? SUPPLY_LOW_LO_TH : SUPPLY_LOW_HI_TH);

    // watchdog timeout select, writable bits 2:0
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            wdt_sel <= WSWS_WDT_SEL_RST;
        end else if (acc_wr && hit_wdt) begin
            wdt_sel <= PWDATA[2:0];
        end
    end

    // overflow flag: set wins, cleared only by power-on or pin reset
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            wdt_flag <= 1'b0;
        end else if (wdt_ovf) begin
            wdt_flag <= 1'b1;
        end else if (pin_rst) begin
            wdt_flag <= 1'b0;
        end
    end

    assign wdt_restart = acc && hit_wdt;
    assign wdt_go      = wdt_en && state != WSWS_ST_RESET;
    assign wdt_load    = WDT_CNT_W'(wsws_wdt_ms(wdt_sel) * WDT_TICKS_PER_MS - 1);

    wsws_wdt #(
        .CNT_W (WDT_CNT_W)
    ) u_wdt (
        .clk      (CORE_CLK),
        .rst      (RST),
        .run      (wdt_go),
        .tick     (WDT_RC_TICK),
        .restart  (wdt_restart),
        .load     (wdt_load),
        .overflow (wdt_ovf),
        .count    (wdt_count)
    );

    // comparator result change detect
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            cmp_prev <= 1'b0;
        end else begin
            cmp_prev <= COMPARATOR_RESULT_BIT;
        end
    end

    assign cmp_wake = CMP_IRQ_EN && (COMPARATOR_RESULT_BIT != cmp_prev);

    // sequencer
    always_comb begin
        next_state    = state;
        next_rst_long = rst_long;
        next_warm_rst = warm_rst;
        wake_evt      = 1'b0;
        if (pin_rst || bor_low) begin
            next_state    = WSWS_ST_RESET;
            next_rst_long = rst_long || pin_rst;
        end else if (wdt_ovf) begin
            next_state    = WSWS_ST_RESET;
            next_rst_long = 1'b0;
        end else begin
            case (state)
                WSWS_ST_RESET: begin
                    next_state    = WSWS_ST_WARM;
                    next_warm_rst = 1'b1;
                end
                WSWS_ST_WARM: begin
                    if (warm_done) begin
                        next_state = WSWS_ST_RUN;
                    end
                end
                WSWS_ST_RUN: begin
                    next_rst_long = 1'b0;
                    if (DEEP_SLEEP_REQ) begin
                        next_state = WSWS_ST_DEEP;
                    end else if (LIGHT_SLEEP_REQ) begin
                        next_state = WSWS_ST_LIGHT;
                    end
                end
                WSWS_ST_LIGHT: begin
                    if (IRQ_ANY || cmp_wake) begin
                        next_state = WSWS_ST_RUN;
                        wake_evt   = 1'b1;
                    end
                end
                WSWS_ST_DEEP: begin
                    if (PORT_IRQ || cmp_wake) begin
                        next_state    = WSWS_ST_WARM;
                        next_warm_rst = 1'b0;
                        wake_evt      = 1'b1;
                    end
                end
                default: begin
                    next_state = WSWS_ST_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            state    <= WSWS_ST_RESET;
            rst_long <= 1'b1;
            warm_rst <= 1'b1;
        end else begin
            state    <= next_state;
            rst_long <= next_rst_long;
            warm_rst <= next_warm_rst;
        end
    end

    // service routine runs first after an interrupt wake
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            isr_pend  <= 1'b0;
            ISR_FIRST <= 1'b0;
        end else if (next_state == WSWS_ST_RESET) begin
            isr_pend  <= 1'b0;
            ISR_FIRST <= 1'b0;
        end else if (wake_evt) begin
            isr_pend  <= 1'b1;
            ISR_FIRST <= 1'b0;
        end else begin
            ISR_FIRST <= isr_pend && state == WSWS_ST_RUN;
            if (state == WSWS_ST_RUN) begin
                isr_pend <= 1'b0;
            end
        end
    end

    // warm-up starts on every entry into the warm state
    assign warm_start = next_state == WSWS_ST_WARM && state != WSWS_ST_WARM;

    always_comb begin
        if (next_warm_rst && next_rst_long) begin
            warm_len = opt[WSWS_OPT_RANGE_BIT] ? WARM_W'(WARM_POR_HI)
                                               : WARM_W'(WARM_POR_LO);
        end else begin
            warm_len = osc_rc ? WARM_W'(WARM_RC) : WARM_W'(WARM_XTAL);
        end
    end

    wsws_warmup #(
        .CNT_W (WARM_W)
    ) u_warm (
        .clk   (CORE_CLK),
        .rst   (RST),
        .start (warm_start),
        .len   (warm_len),
        .busy  (warm_busy),
        .done  (warm_done)
    );

    // registered outputs follow the next state, the port bit 3 gpio select follows the pin option
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            SYS_RESET        <= 1'b1;
            CPU_RUN          <= 1'b0;
            OSC_RUN          <= 1'b1;
            PERIPH_RUN       <= 1'b0;
            WDT_RUN          <= 1'b0;
            CMP_RUN          <= 1'b0;
            PORT_A_BIT3_GPIO <= 1'b0;
        end else begin
            SYS_RESET        <= next_state == WSWS_ST_RESET
                                || (next_state == WSWS_ST_WARM && next_warm_rst);
            CPU_RUN          <= next_state == WSWS_ST_RUN;
            OSC_RUN          <= next_state != WSWS_ST_DEEP;
            PERIPH_RUN       <= next_state == WSWS_ST_RUN
                                || next_state == WSWS_ST_LIGHT;
            WDT_RUN          <= wdt_en && next_state != WSWS_ST_RESET;
            CMP_RUN          <= next_state != WSWS_ST_RESET;
            PORT_A_BIT3_GPIO <= opt[WSWS_OPT_PIN_BIT];
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    sequence light_irq_s;
        state == WSWS_ST_LIGHT && IRQ_ANY && !pin_rst && !bor_low && !wdt_ovf;
    endsequence
    sequence resume_isr_s;
        state == WSWS_ST_RUN ##1 ISR_FIRST;
    endsequence
    sequence deep_port_s;
        state == WSWS_ST_DEEP && PORT_IRQ && !pin_rst && !bor_low && !wdt_ovf;
    endsequence

    wdt_reset_a: assert property (wdt_ovf |=> state == WSWS_ST_RESET ##1 SYS_RESET)
        else $error("watchdog overflow did not reset");
    wdt_flag_a: assert property (wdt_ovf |=> wdt_flag)
        else $error("overflow flag not set");
    wdt_off_a: assert property (!wdt_en && !$past(wdt_en) |-> !wdt_ovf && !WDT_RUN)
        else $error("disabled watchdog active");
    light_wake_a: assert property (light_irq_s |=> resume_isr_s)
        else $error("light sleep wake or service order wrong");
    deep_wake_a: assert property (deep_port_s |=> state == WSWS_ST_WARM && OSC_RUN
                                  ##1 OSC_RUN && !SYS_RESET && !CPU_RUN)
        else $error("deep sleep wake wrong");
    deep_stop_a: assert property (state == WSWS_ST_DEEP |-> !OSC_RUN && !PERIPH_RUN
                                  && CMP_RUN && WDT_RUN == wdt_en)
        else $error("deep sleep run set wrong");
    light_halt_a: assert property (state == WSWS_ST_LIGHT |-> !CPU_RUN && PERIPH_RUN)
        else $error("light sleep run set wrong");
    bor_hold_a: assert property (bor_low |=> SYS_RESET [*2])
        else $error("brownout did not hold reset");
    cmp_wake_a: assert property (state == WSWS_ST_LIGHT && cmp_wake && !pin_rst
                                 && !bor_low && !wdt_ovf |=> state == WSWS_ST_RUN)
        else $error("comparator change did not wake");
    warm_stall_a: assert property (warm_busy |-> !CPU_RUN)
        else $error("cpu ran during warm-up");
    short_warm_a: assert property (warm_start && !next_rst_long && osc_rc
                                   |-> warm_len == WARM_W'(WARM_RC))
        else $error("short warm-up length wrong");
    long_warm_a: assert property (warm_start && next_rst_long && next_warm_rst
                                  && opt[WSWS_OPT_RANGE_BIT]
                                  |-> warm_len == WARM_W'(WARM_POR_HI))
        else $error("long warm-up length wrong");
endmodule : wsws_top
`default_nettype wire

// ===== rtl/wsws_pkg.sv
// shared constants and types of the watchdog, sleep and warm-up supervisor
package wsws_pkg;
    // register indexes; byte address is four times the index
    localparam logic [7:0] WSWS_IDX_WDT  = 8'h1E;
    localparam logic [7:0] WSWS_IDX_OPT  = 8'h20;
    localparam logic [7:0] WSWS_IDX_STAT = 8'h21;
    // watchdog register fields
    localparam int         WSWS_WDT_FLAG_BIT = 3;
    localparam logic [2:0] WSWS_WDT_SEL_RST  = 3'h0;
    // option register fields
    localparam int         WSWS_OPT_RANGE_BIT = 3;
    localparam int         WSWS_OPT_WDT_BIT   = 4;
    localparam int         WSWS_OPT_BOR_BIT   = 5;
    localparam int         WSWS_OPT_LVL_BIT   = 6;
    localparam int         WSWS_OPT_PIN_BIT   = 7;
    localparam logic [7:0] WSWS_OPT_RST       = 8'h78;
    // oscillator type codes
    localparam logic [2:0] WSWS_OSC_EXT  = 3'h0;
    localparam logic [2:0] WSWS_OSC_IRC  = 3'h3;
    localparam logic [2:0] WSWS_OSC_ERC  = 3'h4;
    localparam logic [2:0] WSWS_OSC_CER  = 3'h5;
    localparam logic [2:0] WSWS_OSC_XTL  = 3'h6;
    localparam logic [2:0] WSWS_OSC_X32K = 3'h7;
    // warm-up lengths in oscillator clocks
    localparam int WSWS_WARM_POR_LO = 4096;
    localparam int WSWS_WARM_POR_HI = 16384;
    localparam int WSWS_WARM_RC     = 128;
    localparam int WSWS_WARM_XTAL   = 4096;
    // watchdog tick periods per millisecond of timeout
    localparam int WSWS_WDT_TICKS_PER_MS = 1;

    typedef enum logic [4:0] {
        WSWS_ST_RESET = 5'h01,
        WSWS_ST_WARM  = 5'h02,
        WSWS_ST_RUN   = 5'h04,
        WSWS_ST_LIGHT = 5'h08,
        WSWS_ST_DEEP  = 5'h10
    } wsws_state_t;

    // timeout in milliseconds for a select code
    function automatic int wsws_wdt_ms(input logic [2:0] sel);
        int ms;
        case (sel)
            3'h0:    ms = 4096;
            3'h1:    ms = 1024;
            3'h2:    ms = 256;
            3'h3:    ms = 128;
            3'h4:    ms = 64;
            3'h5:    ms = 16;
            3'h6:    ms = 4;
            default: ms = 1;
        endcase
        return ms;
    endfunction : wsws_wdt_ms
endpackage : wsws_pkg

// ===== rtl/wsws_wdt.sv
// watchdog down-counter advanced by ticks of its own rc oscillator
`timescale 1ns/1ns
`default_nettype none
module wsws_wdt #(
    parameter int CNT_W = 13
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             run,
    input  wire logic             tick,
    input  wire logic             restart,
    input  wire logic [CNT_W-1:0] load,
    output logic                  overflow,
    output logic      [CNT_W-1:0] count
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count    <= '0;
            overflow <= 1'b0;
        end else begin
            overflow <= 1'b0;
            if (!run || restart) begin
                count <= load;
            end else if (tick) begin
                if (count == '0) begin
                    overflow <= 1'b1;
                    count    <= load;
                end else begin
                    count <= count - 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ovf_cause_a: assert property (overflow
        |-> $past(run) && $past(tick) && !$past(restart))
        else $error("watchdog overflow without a tick");
    restart_load_a: assert property (restart && run |=> count == $past(load))
        else $error("watchdog not reloaded on access");
endmodule : wsws_wdt
`default_nettype wire

// ===== rtl/wsws_warmup.sv
// warm-up counter of main oscillator clocks
`timescale 1ns/1ns
`default_nettype none
module wsws_warmup #(
    parameter int CNT_W = 15
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] len,
    output logic                  busy,
    output logic                  done
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] elapsed;
    logic [CNT_W-1:0] len_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt  <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                cnt  <= len - 1'b1;
                busy <= 1'b1;
            end else if (busy && cnt == '0) begin
                busy <= 1'b0;
                done <= 1'b1;
            end else if (busy) begin
                cnt <= cnt - 1'b1;
            end
        end
    end

    // length actually waited
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            elapsed <= '0;
            len_q   <= '0;
        end else if (start) begin
            elapsed <= '0;
            len_q   <= len;
        end else if (busy) begin
            elapsed <= elapsed + 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    warm_len_a: assert property ($rose(done) |-> elapsed == len_q)
        else $error("warm-up length wrong");
endmodule : wsws_warmup
`default_nettype wire

// ===== testbench/wsws_rc_model.sv
// rc tick source standing in for the watchdog's own oscillator
`timescale 1ns/1ns
`default_nettype none
module wsws_rc_model #(
    parameter int PERIOD = 8
) (
    input  wire logic clk,
    input  wire logic rst,
    output logic      tick
);
    int cnt;
    // free-running pulses, unaffected by sleep modes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt  <= 0;
            tick <= 1'b0;
        end else begin
            cnt  <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            tick <= (cnt == PERIOD - 1);
        end
    end
endmodule : wsws_rc_model
`default_nettype wire

// ===== testbench/test_watchdog_sleep_warmup_supervisor.sv
// self-checking bench of the supervisor over apb and control pins
`timescale 1ns/1ns
`default_nettype none
module test_watchdog_sleep_warmup_supervisor;
    import wsws_pkg::*;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, err, tick;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        lreq, dreq, irq, pirq, cen, cres, lhi, llo, pin_n;
    logic        sys_reset, cpu_run, osc_run, periph_run, wdt_run, cmp_run, isr_first, gpio;
    int          err_count, samples_checked, n;

    wsws_top #(.WARM_POR_LO(8), .WARM_POR_HI(16), .WARM_RC(4), .WARM_XTAL(8)) i_wsws_top (
        .CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .WDT_RC_TICK(tick), .LIGHT_SLEEP_REQ(lreq),
        .DEEP_SLEEP_REQ(dreq), .IRQ_ANY(irq), .PORT_IRQ(pirq), .CMP_IRQ_EN(cen),
        .COMPARATOR_RESULT_BIT(cres), .SUPPLY_LOW_HI_TH(lhi), .SUPPLY_LOW_LO_TH(llo),
        .RESET_PIN_N(pin_n), .SYS_RESET(sys_reset), .CPU_RUN(cpu_run), .OSC_RUN(osc_run),
        .PERIPH_RUN(periph_run), .WDT_RUN(wdt_run), .CMP_RUN(cmp_run),
        .ISR_FIRST(isr_first), .PORT_A_BIT3_GPIO(gpio));
    wsws_rc_model i_wsws_rc_model (.clk(clk), .rst(rst), .tick(tick));

    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // one apb transfer; pready, read data and error are taken at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        chk("pready", 1, pready);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask : cyc

    task automatic req(input logic deep);
        @(posedge clk);
        if (deep) dreq <= 1'b1;
        else lreq <= 1'b1;
        @(posedge clk);
        dreq <= 1'b0;
        lreq <= 1'b0;
    endtask : req

    task automatic wait_run;
        n = 0;
        while (cpu_run !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk("cpu_run", 1, cpu_run);
    endtask : wait_run

    task automatic count_isr(input int k);
        n = 0;
        repeat (k) begin
            @(negedge clk);
            if (isr_first === 1'b1) n++;
        end
    endtask : count_isr

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #100000;
        err_count++;
        complete_run();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {lreq, dreq, irq, pirq, cres, lhi, llo} = '0;
        cen = 1'b1;
        pin_n = 1'b1;
        rst = 1'b1;
        err_count = 0;
        samples_checked = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        cyc(10);
        chk("sys_reset", 1, sys_reset);
        chk("cpu_run", 0, cpu_run);
        wait_run();
        apb(0, 8'h78, 0); chk("wdt", 0, rd);
        apb(0, 8'h80, 0); chk("opt", 32'h78, rd);
        apb(1, 8'h7C, 5); chk("pslverr", 1, err);
        apb(0, 8'h84, 0); chk("state", 4, rd);
        $display("test reset done");
        req(0); cyc(3);
        chk("cpu_run", 0, cpu_run);
        chk("periph_run", 1, periph_run);
        chk("wdt_run", 1, wdt_run);
        apb(0, 8'h84, 0); chk("state", 8, rd);
        @(posedge clk);
        irq <= 1'b1;
        count_isr(20); chk("isr", 1, n);
        chk("cpu_run", 1, cpu_run);
        @(posedge clk);
        irq <= 1'b0;
        $display("test light sleep done");
        for (int i = 0; i < 2; i++) begin
            req(1); cyc(3);
            chk("osc_run", 0, osc_run);
            chk("cmp_run", 1, cmp_run);
            chk("wdt_run", 1, wdt_run);
            @(posedge clk);
            irq <= 1'b1;
            cyc(5); chk("cpu_run", 0, cpu_run);
            @(posedge clk);
            irq <= 1'b0;
            if (i == 0) cres <= ~cres;
            else pirq <= 1'b1;
            count_isr(60); chk("isr", 1, n);
            @(posedge clk);
            pirq <= 1'b0;
        end
        $display("test deep sleep done");
        @(posedge clk);
        lhi <= 1'b1;
        cyc(5); chk("sys_reset", 0, sys_reset);
        @(posedge clk);
        llo <= 1'b1;
        cyc(5); chk("sys_reset", 1, sys_reset);
        @(posedge clk);
        lhi <= 1'b0;
        llo <= 1'b0;
        wait_run();
        $display("test brownout done");
        apb(1, 8'h78, 6);
        repeat (8) begin
            cyc(5);
            apb(0, 8'h78, 0); chk("wdt", 6, rd);
            chk("sys_reset", 0, sys_reset);
        end
        n = 0;
        while (sys_reset !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk("sys_reset", 1, sys_reset);
        wait_run();
        apb(1, 8'h78, 0);
        apb(0, 8'h78, 0); chk("wdt_flag", 8, rd);
        $display("test watchdog done");
        @(posedge clk);
        pin_n <= 1'b0;
        cyc(3); chk("sys_reset", 1, sys_reset);
        @(posedge clk);
        pin_n <= 1'b1;
        cyc(10); chk("sys_reset", 1, sys_reset);
        wait_run();
        apb(0, 8'h78, 0); chk("wdt_flag", 0, rd);
        apb(1, 8'h80, 32'hF8);
        cyc(2); chk("gpio", 1, gpio);
        apb(0, 8'h80, 0); chk("opt", 32'h1F8, rd);
        @(posedge clk);
        pin_n <= 1'b0;
        cyc(5); chk("sys_reset", 0, sys_reset);
        @(posedge clk);
        pin_n <= 1'b1;
        $display("test reset pin done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        apb(1, 8'h80, 32'h23);
        wait_run();
        apb(0, 8'h80, 0); chk("opt", 32'h123, rd);
        apb(1, 8'h78, 7);
        cyc(40); chk("sys_reset", 0, sys_reset);
        chk("wdt_run", 0, wdt_run);
        @(posedge clk);
        pin_n <= 1'b0;
        cyc(3); chk("sys_reset", 1, sys_reset);
        @(posedge clk);
        pin_n <= 1'b1;
        wait_run(); chk("pin warm", 11, n);
        @(posedge clk);
        lhi <= 1'b1;
        cyc(3); chk("sys_reset", 1, sys_reset);
        @(posedge clk);
        lhi <= 1'b0;
        wait_run(); chk("rc warm", 7, n);
        $display("test options done");
        complete_run();
    end
endmodule : test_watchdog_sleep_warmup_supervisor
`default_nettype wire
